// File: design/scb_pkg.sv
// package of register map, field layout and reset constants for the scrub config bank
package scb_pkg;
   // byte offsets of the register map
   localparam logic [11:0] SCB_OFS_LINK_TALLY = 12'h16c;
   localparam logic [11:0] SCB_OFS_CH0_CTRL = 12'h170;
   localparam logic [11:0] SCB_OFS_CH0_LOW = 12'h174;
   localparam logic [11:0] SCB_OFS_CH0_HIGH = 12'h178;
   localparam logic [11:0] SCB_OFS_CH1_CTRL = 12'h180;
   localparam logic [11:0] SCB_OFS_CH1_LOW = 12'h184;
   localparam logic [11:0] SCB_OFS_CH1_HIGH = 12'h188;
   localparam logic [11:0] SCB_OFS_IRQ_STATUS = 12'h1f0;
   localparam logic [11:0] SCB_OFS_IRQ_MASK = 12'h1f4;
   localparam logic [11:0] SCB_OFS_CH_STATE = 12'h1f8;
   // channel group spacing and offsets inside a group
   localparam logic [11:0] SCB_CH_STRIDE = 12'h010;
   localparam logic [3:0] SCB_GRP_CTRL = 4'h0;
   localparam logic [3:0] SCB_GRP_LOW = 4'h4;
   localparam logic [3:0] SCB_GRP_HIGH = 4'h8;
   // control register field positions
   localparam int SCB_CAP_LSB = 24;
   localparam int SCB_AGE_LSB = 16;
   localparam int SCB_PAUSE_BIT = 13;
   localparam int SCB_QOS_LSB = 9;
   localparam int SCB_DONE_EV_BIT = 6;
   localparam int SCB_FMT_BIT = 3;
   localparam int SCB_TRIG_LSB = 0;
   // writable bits of the control register, reserved bits zero
   localparam logic [31:0] SCB_CTRL_WMASK = 32'h1f0f_3e4b;
   localparam logic [31:0] SCB_CTRL_RESET = 32'h1f00_0000;
   localparam logic [31:0] SCB_RANGE_RESET = 32'h0000_0000;
   localparam logic [15:0] SCB_TALLY_RESET = 16'h0000;
   // direct coordinate layout
   localparam int SCB_RANK_LSB = 22;
   localparam int SCB_BANK_LSB = 18;
   localparam int SCB_ROW_LSB = 0;
   // interrupt status bits
   localparam int SCB_IRQ_DONE0 = 0;
   localparam int SCB_IRQ_DONE1 = 1;
   localparam int SCB_IRQ_LINK = 2;
   localparam logic [2:0] SCB_IRQ_RESET = 3'h0;
   // escalation prescaler period in cycles
   localparam logic [7:0] SCB_PRESCALE_CYCLES = 8'd100;
   // trigger source encodings
   typedef enum logic [1:0] {
      SCB_TRIG_OFF = 2'b00,
      SCB_TRIG_SOFT = 2'b01,
      SCB_TRIG_EXT0 = 2'b10,
      SCB_TRIG_EXT1 = 2'b11
   } scb_trig_e;
endpackage

// File: design/scb_link_tally.sv
// link fault tally counter with synchronised error inputs
`timescale 1ns/1ps
`default_nettype none
module scb_link_tally
   import scb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // error pins from the phy interface
   input wire logic dfiAlert_n,
   input wire logic dfiErr,
   // software load
   input wire logic loadEn,
   input wire logic [15:0] loadVal,
   // count and new-error pulse
   output logic [15:0] tally,
   output logic newErr
);
   logic [1:0] alertSync_r;
   logic [1:0] errSync_r;
   logic alertSeen_r;
   logic errSeen_r;
   logic alertRise;
   logic errRise;

   // two-stage synchronisers, first stage read only by second
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         alertSync_r <= 2'h0;
         errSync_r <= 2'h0;
      end
      else
      begin
         alertSync_r <= {alertSync_r[0], ~dfiAlert_n};
         errSync_r <= {errSync_r[0], dfiErr};
      end
   end

   // edge history so a held error counts once
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         alertSeen_r <= 1'b0;
         errSeen_r <= 1'b0;
      end
      else
      begin
         alertSeen_r <= alertSync_r[1];
         errSeen_r <= errSync_r[1];
      end
   end

   assign alertRise = alertSync_r[1] & ~alertSeen_r;
   assign errRise = errSync_r[1] & ~errSeen_r;

   // software load wins over a count in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         tally <= SCB_TALLY_RESET;
         newErr <= 1'b0;
      end
      else
      begin
         newErr <= alertRise | errRise;
         if (loadEn)
            tally <= loadVal;
         else if (alertRise | errRise)
            tally <= tally + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// File: design/scb_chan_seq.sv
// per-channel scrub sequencer: range walk, in-flight cap, escalation, pause, done event
`timescale 1ns/1ps
`default_nettype none
module scb_chan_seq
   import scb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // configuration
   input wire logic [31:0] ctrl,
   input wire logic [31:0] rangeLow,
   input wire logic [31:0] rangeHigh,
   input wire logic softStart,
   input wire logic [1:0] extTrig,
   input wire logic prescaleTick,
   input wire logic resume,
   // request port toward the memory scheduler
   output logic reqValid,
   input wire logic reqReady,
   input wire logic reqDone,
   output logic [31:0] reqAddr,
   output logic [3:0] reqQos,
   output logic reqHostFmt,
   output logic [2:0] reqRank,
   output logic [3:0] reqBank,
   output logic [17:0] reqRow,
   output logic [3:0] reqPrio,
   // status
   output logic busy,
   output logic paused,
   output logic doneEvent
);
   typedef enum logic [1:0] {
      SCB_IDLE = 2'b00,
      SCB_RUN = 2'b01,
      SCB_PAUSE = 2'b10,
      SCB_DRAIN = 2'b11
   } scb_seq_e;

   scb_seq_e state_r;
   logic [5:0] inFlight_r;
   logic [3:0] ageCnt_r;
   logic [4:0] cap;
   logic [3:0] age;
   logic start;
   logic issue;
   logic lastAddr;
   logic pageEdge;

   assign cap = ctrl[SCB_CAP_LSB +: 5];
   assign age = ctrl[SCB_AGE_LSB +: 4];

   // trigger source decode
   always_comb
   begin
      unique case (scb_trig_e'(ctrl[SCB_TRIG_LSB +: 2]))
         SCB_TRIG_OFF: start = 1'b0;
         SCB_TRIG_SOFT: start = softStart;
         SCB_TRIG_EXT0: start = extTrig[0];
         SCB_TRIG_EXT1: start = extTrig[1];
      endcase
   end

   // never issue with the cap reached
   assign issue = reqValid & reqReady;
   assign reqValid = (state_r == SCB_RUN) && (inFlight_r < {1'b0, cap});
   assign lastAddr = reqAddr == rangeHigh;
   assign pageEdge = ctrl[SCB_PAUSE_BIT] && (reqAddr[9:0] == 10'h3ff);
   assign busy = state_r != SCB_IDLE;
   assign paused = state_r == SCB_PAUSE;
   assign reqQos = ctrl[SCB_QOS_LSB +: 4];
   assign reqHostFmt = ctrl[SCB_FMT_BIT];
   assign reqRank = reqAddr[SCB_RANK_LSB +: 3];
   assign reqBank = reqAddr[SCB_BANK_LSB +: 4];
   assign reqRow = reqAddr[SCB_ROW_LSB +: 18];

   // sequence and address walk
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_r <= SCB_IDLE;
         reqAddr <= SCB_RANGE_RESET;
         doneEvent <= 1'b0;
      end
      else
      begin
         doneEvent <= 1'b0;
         unique case (state_r)
            SCB_IDLE:
               if (start)
               begin
                  state_r <= SCB_RUN;
                  reqAddr <= rangeLow;
               end
            SCB_RUN:
               if (issue)
               begin
                  if (lastAddr)
                     state_r <= SCB_DRAIN;
                  else
                  begin
                     reqAddr <= reqAddr + 32'h1;
                     if (pageEdge)
                        state_r <= SCB_PAUSE;
                  end
               end
            SCB_PAUSE:
               if (resume)
                  state_r <= SCB_RUN;
            SCB_DRAIN:
               if (inFlight_r == 6'h0)
               begin
                  state_r <= SCB_IDLE;
                  doneEvent <= ctrl[SCB_DONE_EV_BIT];
               end
         endcase
      end
   end

   // outstanding request count
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         inFlight_r <= 6'h0;
      else if (issue && !reqDone)
         inFlight_r <= inFlight_r + 6'h1;
      else if (!issue && reqDone && inFlight_r != 6'h0)
         inFlight_r <= inFlight_r - 6'h1;
   end

   // priority escalation after age prescaler periods, zero disables
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ageCnt_r <= 4'h0;
         reqPrio <= 4'h0;
      end
      else if (state_r == SCB_IDLE || issue || age == 4'h0)
      begin
         ageCnt_r <= 4'h0;
         reqPrio <= 4'h0;
      end
      else if (prescaleTick)
      begin
         if (ageCnt_r + 4'h1 >= age)
         begin
            ageCnt_r <= 4'h0;
            if (reqPrio != 4'hf)
               reqPrio <= reqPrio + 4'h1;
         end
         else
            ageCnt_r <= ageCnt_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

// File: design/scb_config_regs.sv
// AHB-Lite register bank for scrub channel configuration and link fault tally
// Function
// - a write to the tally loads it; counting continues from there
// - tally increments once per cycle with a new link alert or link error; both in one cycle count once
// - in-flight cap 8..31 set by software; never exceeded by the device
// - priority rises after age periods elapse; zero disables escalation
// - pause-at-page bit pauses the program at a page boundary
// - scrub operations carry the channel service level
// - done event emitted on sequence end only when enabled
// - range format bit picks direct coordinates or host format
// - trigger source field selects the start event
// - direct format is rank 24:22, bank 21:18, row 17:0
// - host format uses system transaction address layout
// - pass starts at the low range register
// - pass ends at the high range register
// - all registers accessible in every state
// - channel groups 0x10 apart: control, low +4, high +8
`timescale 1ns/1ps
`default_nettype none
module scb_config_regs
   import scb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // link error pins
   input wire logic dfiAlert_n,
   input wire logic dfiErr,
   // scrub triggers and scheduler handshake
   input wire logic [1:0] extTrig,
   input wire logic [1:0] reqReady,
   input wire logic [1:0] reqDone,
   output logic [1:0] reqValid,
   output logic [63:0] reqAddr,
   output logic [7:0] reqQos,
   output logic [1:0] reqHostFmt,
   output logic [7:0] reqPrio,
   // interrupt
   output logic irq
);
   logic [31:0] ctrl_r [2];
   logic [31:0] low_r [2];
   logic [31:0] high_r [2];
   logic [2:0] irqStat_r;
   logic [2:0] irqMask_r;
   logic [1:0] softStart_r;
   logic [1:0] resume_r;
   logic [7:0] preCnt_r;
   logic preTick;
   logic wrPend_r;
   logic [11:0] wrAddr_r;
   logic [15:0] tally;
   logic linkNew;
   logic tallyLoad;
   logic [1:0] chBusy;
   logic [1:0] chPaused;
   logic [1:0] chDone;
   logic [31:0] chAddr [2];
   logic [2:0] rdRank [2];
   logic [3:0] rdBank [2];
   logic [17:0] rdRow [2];
   logic addrPhase;
   logic [31:0] rdMux;
   logic [2:0] wrDec;
   logic [2:0] rdDec;

   // hit flag and channel index of an address, used for write and read
   function automatic logic [2:0] decodeChan(input logic [11:0] a);
      logic [11:0] rel;
      rel = a - SCB_OFS_CH0_CTRL;
      if (a >= SCB_OFS_CH0_CTRL && rel < (SCB_CH_STRIDE << 1) && rel[3:0] != 4'hc)
         decodeChan = {1'b1, rel[4], 1'b0};
      else
         decodeChan = 3'h0;
   endfunction

   assign addrPhase = hsel & htrans[1] & hready;
   assign tallyLoad = wrPend_r && wrAddr_r == SCB_OFS_LINK_TALLY;
   // channel decode of the write address and of the live read address
   assign wrDec = decodeChan(wrAddr_r);
   assign rdDec = decodeChan(haddr);

   // address phase capture; writes complete in the data phase
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 12'h000;
      end
      else if (hready)
      begin
         wrPend_r <= addrPhase & hwrite;
         wrAddr_r <= haddr;
      end
   end

   // zero wait state, always OKAY, no state-based blocking
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // channel register writes, reserved bits masked
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < 2; i++)
         begin
            ctrl_r[i] <= SCB_CTRL_RESET;
            low_r[i] <= SCB_RANGE_RESET;
            high_r[i] <= SCB_RANGE_RESET;
         end
      end
      else if (wrPend_r && wrDec[2])
      begin
         unique case (wrAddr_r[3:0])
            SCB_GRP_CTRL: ctrl_r[wrDec[1]] <= hwdata & SCB_CTRL_WMASK;
            SCB_GRP_LOW: low_r[wrDec[1]] <= hwdata;
            SCB_GRP_HIGH: high_r[wrDec[1]] <= hwdata;
            default: ;
         endcase
      end
   end

   // soft start and resume pulses from a one written to the state register
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         softStart_r <= 2'h0;
         resume_r <= 2'h0;
      end
      else if (wrPend_r && wrAddr_r == SCB_OFS_CH_STATE)
      begin
         softStart_r <= hwdata[1:0];
         resume_r <= hwdata[5:4];
      end
      else
      begin
         softStart_r <= 2'h0;
         resume_r <= 2'h0;
      end
   end

   // interrupt status sticky, write one clears, a new event wins
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         irqStat_r <= SCB_IRQ_RESET;
         irqMask_r <= SCB_IRQ_RESET;
         irq <= 1'b0;
      end
      else
      begin
         if (wrPend_r && wrAddr_r == SCB_OFS_IRQ_MASK)
            irqMask_r <= hwdata[2:0];
         irqStat_r <= (irqStat_r & ~((wrPend_r && wrAddr_r == SCB_OFS_IRQ_STATUS) ?
                      hwdata[2:0] : 3'h0)) | {linkNew, chDone};
         irq <= |(irqStat_r & irqMask_r);
      end
   end

   // escalation prescaler, a one-cycle tick
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         preCnt_r <= 8'h00;
      else if (preCnt_r == SCB_PRESCALE_CYCLES - 8'd1)
         preCnt_r <= 8'h00;
      else
         preCnt_r <= preCnt_r + 8'h01;
   end
   assign preTick = preCnt_r == SCB_PRESCALE_CYCLES - 8'd1;

   scb_link_tally u_tally (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .dfiAlert_n(dfiAlert_n),
      .dfiErr(dfiErr),
      .loadEn(tallyLoad),
      .loadVal(hwdata[15:0]),
      .tally(tally),
      .newErr(linkNew)
   );

   // one sequencer per channel
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      scb_chan_seq u_seq (
         .sys_clk(sys_clk),
         .reset_n(reset_n),
         .ctrl(ctrl_r[c]),
         .rangeLow(low_r[c]),
         .rangeHigh(high_r[c]),
         .softStart(softStart_r[c]),
         .extTrig(extTrig),
         .prescaleTick(preTick),
         .resume(resume_r[c]),
         .reqValid(reqValid[c]),
         .reqReady(reqReady[c]),
         .reqDone(reqDone[c]),
         .reqAddr(chAddr[c]),
         .reqQos(reqQos[4*c +: 4]),
         .reqHostFmt(reqHostFmt[c]),
         .reqRank(rdRank[c]),
         .reqBank(rdBank[c]),
         .reqRow(rdRow[c]),
         .reqPrio(reqPrio[4*c +: 4]),
         .busy(chBusy[c]),
         .paused(chPaused[c]),
         .doneEvent(chDone[c])
      );
      assign reqAddr[32*c +: 32] = reqHostFmt[c] ? chAddr[c] :
         {7'h00, rdRank[c], rdBank[c], rdRow[c]};
   end

   // read mux, unmapped and reserved read zero
   always_comb
   begin
      rdMux = 32'h0;
      if (rdDec[2])
      begin
         unique case (haddr[3:0])
            SCB_GRP_CTRL: rdMux = ctrl_r[rdDec[1]];
            SCB_GRP_LOW: rdMux = low_r[rdDec[1]];
            SCB_GRP_HIGH: rdMux = high_r[rdDec[1]];
            default: rdMux = 32'h0;
         endcase
      end
      else if (haddr == SCB_OFS_LINK_TALLY)
         rdMux = {16'h0000, tally};
      else if (haddr == SCB_OFS_IRQ_STATUS)
         rdMux = {29'h0, irqStat_r};
      else if (haddr == SCB_OFS_IRQ_MASK)
         rdMux = {29'h0, irqMask_r};
      else if (haddr == SCB_OFS_CH_STATE)
         rdMux = {24'h0, 2'h0, chPaused, 2'h0, chBusy};
   end

   // read data registered at the address phase, valid in the data phase
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         hrdata <= 32'h0;
      else if (addrPhase && !hwrite)
         hrdata <= rdMux;
   end
endmodule
`default_nettype wire

// File: bench/scb_config_regs_properties.sv
// port-level assertion checker for the scrub config register bank
`timescale 1ns/1ps
`default_nettype none
module scb_config_regs_properties
   import scb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // bus side
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // scheduler side
   input wire logic [1:0] reqValid,
   input wire logic [1:0] reqReady,
   input wire logic [1:0] reqDone,
   input wire logic [7:0] reqQos,
   input wire logic [1:0] reqHostFmt,
   input wire logic irq
);
   logic rdTaken;
   logic wrTaken;
   logic [5:0] inFlight0_r;
   logic [5:0] inFlight1_r;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // address phases taken by the slave
   assign rdTaken = hsel && htrans[1] && hready && !hwrite;
   assign wrTaken = hsel && htrans[1] && hready && hwrite;
   // outstanding requests per channel, accepted minus completed
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         inFlight0_r <= 6'h00;
         inFlight1_r <= 6'h00;
      end
      else
      begin
         inFlight0_r <= inFlight0_r + 6'(reqValid[0] & reqReady[0]) - 6'(reqDone[0]);
         inFlight1_r <= inFlight1_r + 6'(reqValid[1] & reqReady[1]) - 6'(reqDone[1]);
      end
   end
   ready_always_a: assert property (hreadyout)
      else $error("slave inserted a wait state");
   okay_resp_a: assert property (!hresp)
      else $error("slave answered with an error");
   rdata_hold_a: assert property (!$past(rdTaken) |-> $stable(hrdata))
      else $error("read data moved without a read");
   // config outputs change only two edges after a taken write
   qos_stable_a: assert property ($past(reset_n) && !$past(wrTaken, 2)
      |-> $stable(reqQos))
      else $error("service level moved without a write");
   fmt_stable_a: assert property ($past(reset_n) && !$past(wrTaken, 2)
      |-> $stable(reqHostFmt))
      else $error("range format moved without a write");
   cap0_limit_a: assert property (inFlight0_r <= 6'd31)
      else $error("channel 0 exceeds the widest cap");
   cap1_limit_a: assert property (inFlight1_r <= 6'd31)
      else $error("channel 1 exceeds the widest cap");
   reset_quiet_a: assert property (disable iff (1'b0) !reset_n
      |=> reqValid == 2'b00 && hrdata == 32'h0 && !irq)
      else $error("outputs not quiet after reset");
   // main scenarios reached
   cover property (rdTaken);
   cover property ($rose(irq));
   cover property (reqValid[1] && reqReady[1]);
endmodule
`default_nettype wire

// File: bench/scb_config_regs_bench.sv
// self-checking bench for the scrub config register bank
`timescale 1ns/1ps
`default_nettype none
module scb_config_regs_bench
   import scb_pkg::*;
   ;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic dfiAlert_n = 1'b1;
   logic dfiErr = 1'b0;
   logic [1:0] extTrig = 2'b00;
   logic [1:0] reqReady = 2'b00;
   logic [1:0] reqDone = 2'b00;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [1:0] reqValid;
   logic [63:0] reqAddr;
   logic [7:0] reqQos;
   logic [1:0] reqHostFmt;
   logic [7:0] reqPrio;
   logic irq;
   int errors = 0;
   int nChecks = 0;
   // register table: address, reset value, writable bits
   logic [11:0] regA [7] = '{SCB_OFS_CH0_CTRL, SCB_OFS_CH0_LOW, SCB_OFS_CH0_HIGH,
      SCB_OFS_CH1_CTRL, SCB_OFS_CH1_LOW, SCB_OFS_CH1_HIGH, SCB_OFS_LINK_TALLY};
   logic [31:0] regR [7] = '{SCB_CTRL_RESET, SCB_RANGE_RESET, SCB_RANGE_RESET,
      SCB_CTRL_RESET, SCB_RANGE_RESET, SCB_RANGE_RESET, 32'(SCB_TALLY_RESET)};
   logic [31:0] regM [7] = '{SCB_CTRL_WMASK, 32'hffffffff, 32'hffffffff,
      SCB_CTRL_WMASK, 32'hffffffff, 32'hffffffff, 32'h0000ffff};
   // single slave, so its ready is the bus ready
   scb_config_regs dut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dfiAlert_n, .dfiErr, .extTrig,
      .reqReady, .reqDone, .reqValid, .reqAddr, .reqQos, .reqHostFmt, .reqPrio, .irq);
   // 50 MHz clock
   initial
   begin
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, seen);
         errors++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one single transfer; called just after a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(what, x, exp);
   endtask
   // bounded wait for a channel request
   task automatic waitReq(input int c);
      for (int i = 0; i < 30 && reqValid[c] !== 1'b1; i++)
         tick(1);
   endtask
   function automatic logic [31:0] ctrlWord(input int cap, age, qos, done, fmt, trig);
      return (32'(cap) << SCB_CAP_LSB) | (32'(age) << SCB_AGE_LSB) | (32'(qos) << SCB_QOS_LSB)
         | (32'(done) << SCB_DONE_EV_BIT) | (32'(fmt) << SCB_FMT_BIT) | 32'(trig);
   endfunction
   function automatic logic [31:0] directAddr(input logic [31:0] v);
      return {7'h00, v[24:0]};
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // watchdog: whole sequence needs under 3000 cycles
   initial
   begin
      tick(20000);
      errors++;
      test_done();
   end
   initial
   begin
      logic [31:0] v;
      logic [31:0] lo;
      int n;
      int q;
      void'($urandom(70));
      tick(5);
      reset_n <= 1'b1;
      tick(1);
      // reset values, then random write-back through writable bits only
      for (int i = 0; i < 7; i++)
      begin
         rdc("reset value", regA[i], regR[i]);
         v = $urandom;
         if (regM[i] == SCB_CTRL_WMASK)
            v[28:24] = 5'(8 + v[28:24] % 24);
         wr(regA[i], v);
         rdc("readback", regA[i], v & regM[i]);
      end
      // random trigger code would let external pulses start channel 0 early
      wr(SCB_OFS_CH0_CTRL, SCB_CTRL_RESET);
      wr(12'h100, 32'hffffffff);
      rdc("unmapped", 12'h100, 32'h0);
      $display("test register map done");
      // load tally, then alternate error pins; bit 15 clear avoids wrap
      lo = $urandom & 32'hffff7fff;
      wr(SCB_OFS_LINK_TALLY, lo);
      n = 1 + $urandom % 4;
      for (int i = 0; i < n; i++)
      begin
         dfiAlert_n <= (i % 2 == 0);
         dfiErr <= (i % 2 == 0);
         tick(2);
         dfiAlert_n <= 1'b1;
         dfiErr <= 1'b0;
         tick(4);
      end
      rdc("tally", SCB_OFS_LINK_TALLY, 32'(lo[15:0] + 16'(n)));
      chk("irq masked", irq, 1'b0);
      wr(SCB_OFS_IRQ_MASK, 32'h7);
      tick(2);
      chk("irq raised", irq, 1'b1);
      rdc("status", SCB_OFS_IRQ_STATUS, 32'h4);
      wr(SCB_OFS_IRQ_STATUS, 32'h4);
      tick(2);
      chk("irq cleared", irq, 1'b0);
      $display("test link tally done");
      // every trigger code, one-address pass, done event on second lap only
      for (int k = 0; k < 8; k++)
      begin
         q = $urandom % 16;
         lo = $urandom;
         wr(SCB_OFS_CH1_CTRL, ctrlWord(8, 0, q, k / 4, 1, k % 4));
         wr(SCB_OFS_CH1_LOW, lo);
         wr(SCB_OFS_CH1_HIGH, lo);
         extTrig <= 2'(k % 4 / 2 * (k % 2 + 1));
         if (k % 4 < 2)
            wr(SCB_OFS_CH_STATE, 32'h2);
         else
            tick(1);
         extTrig <= 2'b00;
         waitReq(1);
         chk("started", reqValid[1], k % 4 != 0);
         if (k % 4 != 0)
         begin
            chk("first address", reqAddr[63:32], lo);
            chk("service level", reqQos[7:4], q);
            chk("host format", reqHostFmt[1], 1'b1);
            reqReady[1] <= 1'b1;
            tick(1);
            reqReady[1] <= 1'b0;
            reqDone[1] <= 1'b1;
            tick(1);
            reqDone[1] <= 1'b0;
            chk("range end", reqValid[1], 1'b0);
            tick(4);
            rdc("done event", SCB_OFS_IRQ_STATUS, 32'(k / 4 * 2));
            wr(SCB_OFS_IRQ_STATUS, 32'h3);
         end
      end
      $display("test triggers done");
      // long direct-format pass against cap 8 with the scheduler never completing
      q = $urandom % 16;
      lo = {7'h7f, 1'b0, 24'($urandom)};
      wr(SCB_OFS_CH0_CTRL, ctrlWord(8, 1, q, 0, 0, 1));
      wr(SCB_OFS_CH0_LOW, lo);
      wr(SCB_OFS_CH0_HIGH, 32'h01ffffff);
      wr(SCB_OFS_CH_STATE, 32'h1);
      waitReq(0);
      chk("direct address", reqAddr[31:0], directAddr(lo));
      chk("direct format", reqHostFmt[0], 1'b0);
      v = 32'(reqPrio[3:0]);
      reqReady[0] <= 1'b1;
      n = 0;
      repeat (60)
      begin
         @(posedge sys_clk);
         n += int'(reqValid[0] & reqReady[0]);
      end
      reqReady[0] <= 1'b0;
      chk("in-flight cap", n, 8);
      tick(250);
      chk("escalated", reqPrio[3:0] > v[3:0], 1'b1);
      $display("test cap and escalation done");
      // channel 1 pauses after a page's last address, resume runs it to the end
      wr(SCB_OFS_CH1_CTRL, ctrlWord(8, 0, 0, 1, 1, 1) | (32'h1 << SCB_PAUSE_BIT));
      wr(SCB_OFS_CH1_LOW, 32'h000003fe);
      wr(SCB_OFS_CH1_HIGH, 32'h00000401);
      wr(SCB_OFS_CH_STATE, 32'h2);
      reqReady[1] <= 1'b1;
      tick(20);
      rdc("paused state", SCB_OFS_CH_STATE, 32'h23);
      wr(SCB_OFS_CH_STATE, 32'h20);
      tick(6);
      reqReady[1] <= 1'b0;
      reqDone[1] <= 1'b1;
      tick(4);
      reqDone[1] <= 1'b0;
      tick(2);
      rdc("pass end", SCB_OFS_CH_STATE, 32'h1);
      rdc("done enabled", SCB_OFS_IRQ_STATUS, 32'h2);
      $display("test page pause done");
      test_done();
   end
endmodule
bind scb_config_regs scb_config_regs_properties props (.sys_clk, .reset_n, .hsel, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .reqValid, .reqReady, .reqDone, .reqQos,
   .reqHostFmt, .irq);
`default_nettype wire
